// file: inc/hpcs_pkg.sv
// Shared constants for the host pin control and status block.
package hpcs_pkg;

  // Number of synthesis loops and of clock outputs.
  localparam int HPCS_NUM_LOOPS = 4;
  localparam int HPCS_NUM_OUTS = 8;
  localparam int HPCS_STEP_W = 16;

  // Input synchroniser depth, fixed at three stages.
  localparam int HPCS_SYNC_STAGES = 3;

  // Positions of the host-facing pins in the synchroniser vector.
  localparam int HPCS_PIN_RST = 0;
  localparam int HPCS_PIN_IFSEL = 1;
  localparam int HPCS_PIN_SELN = 2;
  localparam int HPCS_PIN_SCLK = 3;
  localparam int HPCS_PIN_A1 = 4;
  localparam int HPCS_PIN_OE0 = 5;
  localparam int HPCS_PIN_OE1 = 6;
  localparam int HPCS_PIN_LSEL0 = 7;
  localparam int HPCS_PIN_LSEL1 = 8;
  localparam int HPCS_PIN_UP = 9;
  localparam int HPCS_PIN_DN = 10;
  localparam int HPCS_NUM_PINS = 11;

  // Value every synchroniser stage takes under the asynchronous reset.
  localparam logic [HPCS_NUM_PINS-1:0] HPCS_PIN_RST_VAL = 11'h000;

  // Configuration defaults loaded at reset.
  localparam logic [HPCS_NUM_OUTS-1:0] HPCS_OE0_MASK_RST = 8'hff;
  localparam logic [HPCS_NUM_OUTS-1:0] HPCS_OE1_MASK_RST = 8'h00;
  localparam logic [HPCS_STEP_W-1:0] HPCS_STEP_SIZE_RST = 16'h0001;
  localparam logic HPCS_FOUR_WIRE_RST = 1'b1;
  localparam logic HPCS_IO_VDD_SEL_RST = 1'b0;

endpackage : hpcs_pkg

// file: inc/hpcs_step_if.sv
// Carrier between the pin logic and the frequency step generator.
`timescale 1ns/1ps
interface hpcs_step_if #(
  parameter int NL = 4
);
  logic soft_rst;
  logic up_lvl;
  logic down_lvl;
  logic [1:0] sel;
  logic [NL-1:0] step_up;
  logic [NL-1:0] step_down;

  modport pins (output soft_rst, output up_lvl, output down_lvl, output sel,
                input step_up, input step_down);
  modport gen (input soft_rst, input up_lvl, input down_lvl, input sel,
               output step_up, output step_down);
endinterface : hpcs_step_if

// file: core/hpcs_step_gen.sv
// Frequency step generator: one step pulse per rising pin edge, none when both pins rise together.
`timescale 1ns/1ps
module hpcs_step_gen
  import hpcs_pkg::*;
#(
  parameter int NL = HPCS_NUM_LOOPS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Pin side carrier
  hpcs_step_if.gen sif
);

  logic up_prev_q;
  logic down_prev_q;
  logic up_rise;
  logic down_rise;

  // Previous levels; a held level never produces a second edge.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      up_prev_q <= 1'b0;
      down_prev_q <= 1'b0;
    end else begin
      up_prev_q <= sif.up_lvl;
      down_prev_q <= sif.down_lvl;
    end
  end

  // Edges that land together cancel, since the net frequency change is nil.
  assign up_rise = sif.up_lvl & ~up_prev_q & ~(sif.down_lvl & ~down_prev_q);
  assign down_rise = sif.down_lvl & ~down_prev_q & ~(sif.up_lvl & ~up_prev_q);

  // Route each edge only to the loop named by the select pins.
  for (genvar k = 0; k < NL; k++) begin : g_loop
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        sif.step_up[k] <= 1'b0;
        sif.step_down[k] <= 1'b0;
      end else if (sif.soft_rst) begin
        sif.step_up[k] <= 1'b0;
        sif.step_down[k] <= 1'b0;
      end else begin
        sif.step_up[k] <= up_rise && (32'(sif.sel) == k);
        sif.step_down[k] <= down_rise && (32'(sif.sel) == k);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_up_edge;
    !sif.up_lvl ##1 sif.up_lvl && !sif.down_lvl && !sif.soft_rst;
  endsequence
  sequence s_down_edge;
    !sif.down_lvl ##1 sif.down_lvl && !sif.up_lvl && !sif.soft_rst;
  endsequence

  a_up_to_loop: assert property (s_up_edge |=>
    sif.step_up == NL'(1 << $past(sif.sel)))
    else $error("Up edge did not step the selected loop.");
  a_down_to_loop: assert property (s_down_edge |=>
    sif.step_down == NL'(1 << $past(sif.sel)))
    else $error("Down edge did not step the selected loop.");
  a_one_loop_only: assert property ($onehot0(sif.step_up | sif.step_down))
    else $error("More than one loop stepped at once.");
  a_held_no_step: assert property (sif.up_lvl [*2] |-> ##1
    sif.step_up == '0)
    else $error("Held up level produced another step.");

endmodule : hpcs_step_gen

// file: core/hpcs_top.sv
// Host pin control and status logic of a multi-loop clock generator.
`timescale 1ns/1ps
module hpcs_top
  import hpcs_pkg::*;
#(
  parameter int NL = HPCS_NUM_LOOPS,
  parameter int NO = HPCS_NUM_OUTS,
  parameter int SW = HPCS_STEP_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Host serial pins
  input wire logic device_reset_n,
  input wire logic iface_sel,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic addr_strap_one,
  output logic serial_read_out,
  output logic serial_read_out_oe,
  // Board control and status pins
  input wire logic out_en_zero_n,
  input wire logic out_en_one_n,
  input wire logic [1:0] loop_select,
  input wire logic freq_step_up,
  input wire logic freq_step_down,
  output logic irq_out_n,
  output logic unlocked_loop_a_n,
  output logic unlocked_loop_b_n,
  output logic unlocked_loop_c_n,
  output logic unlocked_loop_d_n,
  output logic ref_signal_lost_n,
  // Configuration from the device core
  input wire logic cfg_wr,
  input wire logic [NO-1:0] cfg_oe0_mask,
  input wire logic [NO-1:0] cfg_oe1_mask,
  input wire logic [SW-1:0] cfg_step_size,
  input wire logic cfg_four_wire,
  input wire logic cfg_io_vdd_sel,
  // Events and status from the device core
  input wire logic spi_read_bit,
  input wire logic spi_read_active,
  input wire logic status_event,
  input wire logic irq_clear,
  input wire logic [NL-1:0] loop_locked,
  input wire logic ref_xtal_fail,
  input wire logic ref_input_lost,
  // Results to the device core
  output logic core_in_reset,
  output logic i2c_mode,
  output logic [1:0] bus_addr_straps,
  output logic spi_selected,
  output logic serial_clk_level,
  output logic read_level_sel,
  output logic [NO-1:0] clk_out_en,
  output logic [NL-1:0] loop_step_up,
  output logic [NL-1:0] loop_step_down,
  output logic [SW-1:0] step_size
);

  logic [HPCS_NUM_PINS-1:0] pin_raw;
  logic [HPCS_NUM_PINS-1:0] pin_s1_q;
  logic [HPCS_NUM_PINS-1:0] pin_s2_q;
  logic [HPCS_NUM_PINS-1:0] pin_s3_q;
  logic [HPCS_NUM_PINS-1:0] pin_q;
  logic soft_rst;
  logic [NO-1:0] oe0_mask_q;
  logic [NO-1:0] oe1_mask_q;
  logic [SW-1:0] step_size_q;
  logic four_wire_q;
  logic io_vdd_sel_q;
  logic [NL-1:0] locked_q;
  logic irq_n_q;
  logic ref_lost_n_q;
  logic i2c_q;
  logic spi_sel_q;
  logic [1:0] addr_q;
  logic sclk_q;
  logic rd_out_q;
  logic rd_oe_q;
  logic rd_lvl_q;
  logic [NO-1:0] clk_en_q;
  logic rst_q;

  hpcs_step_if #(.NL(NL)) sif ();

  // Gather pins into one vector so a single loop builds all synchronisers.
  assign pin_raw[HPCS_PIN_RST] = device_reset_n;
  assign pin_raw[HPCS_PIN_IFSEL] = iface_sel;
  assign pin_raw[HPCS_PIN_SELN] = select_n;
  assign pin_raw[HPCS_PIN_SCLK] = serial_clk;
  assign pin_raw[HPCS_PIN_A1] = addr_strap_one;
  assign pin_raw[HPCS_PIN_OE0] = out_en_zero_n;
  assign pin_raw[HPCS_PIN_OE1] = out_en_one_n;
  assign pin_raw[HPCS_PIN_LSEL0] = loop_select[0];
  assign pin_raw[HPCS_PIN_LSEL1] = loop_select[1];
  assign pin_raw[HPCS_PIN_UP] = freq_step_up;
  assign pin_raw[HPCS_PIN_DN] = freq_step_down;

  // Three-stage synchroniser; a change is accepted once stages two and three agree.
  for (genvar i = 0; i < HPCS_NUM_PINS; i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        pin_s1_q[i] <= HPCS_PIN_RST_VAL[i];
        pin_s2_q[i] <= HPCS_PIN_RST_VAL[i];
        pin_s3_q[i] <= HPCS_PIN_RST_VAL[i];
        pin_q[i] <= HPCS_PIN_RST_VAL[i];
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_s3_q[i] <= pin_s2_q[i];
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  assign soft_rst = ~pin_q[HPCS_PIN_RST];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= soft_rst;
    end
  end

  // Configuration registers; the reset pin reloads them like a power-on.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe0_mask_q <= HPCS_OE0_MASK_RST;
      oe1_mask_q <= HPCS_OE1_MASK_RST;
      step_size_q <= HPCS_STEP_SIZE_RST;
      four_wire_q <= HPCS_FOUR_WIRE_RST;
      io_vdd_sel_q <= HPCS_IO_VDD_SEL_RST;
    end else if (soft_rst) begin
      oe0_mask_q <= HPCS_OE0_MASK_RST;
      oe1_mask_q <= HPCS_OE1_MASK_RST;
      step_size_q <= HPCS_STEP_SIZE_RST;
      four_wire_q <= HPCS_FOUR_WIRE_RST;
      io_vdd_sel_q <= HPCS_IO_VDD_SEL_RST;
    end else if (cfg_wr) begin
      oe0_mask_q <= cfg_oe0_mask;
      oe1_mask_q <= cfg_oe1_mask;
      step_size_q <= cfg_step_size;
      four_wire_q <= cfg_four_wire;
      io_vdd_sel_q <= cfg_io_vdd_sel;
    end
  end

  // Host interface mode, address straps, chip select and serial clock.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      i2c_q <= 1'b0;
      spi_sel_q <= 1'b0;
      addr_q <= 2'h0;
      sclk_q <= 1'b0;
    end else begin
      i2c_q <= pin_q[HPCS_PIN_IFSEL];
      spi_sel_q <= ~pin_q[HPCS_PIN_IFSEL] & ~pin_q[HPCS_PIN_SELN] & ~soft_rst;
      addr_q[0] <= pin_q[HPCS_PIN_IFSEL] & pin_q[HPCS_PIN_SELN];
      addr_q[1] <= pin_q[HPCS_PIN_IFSEL] & pin_q[HPCS_PIN_A1];
      sclk_q <= pin_q[HPCS_PIN_SCLK];
    end
  end

  // Shared pin driver; in I2C mode it is released so the strap can be read.
  // In 3-wire SPI the read data leaves on the data pin, so this pin stays off.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_oe_q <= 1'b0;
      rd_out_q <= 1'b0;
      rd_lvl_q <= 1'b0;
    end else begin
      rd_oe_q <= ~pin_q[HPCS_PIN_IFSEL] & four_wire_q & ~pin_q[HPCS_PIN_SELN]
                 & spi_read_active & ~soft_rst;
      rd_out_q <= spi_read_bit;
      rd_lvl_q <= io_vdd_sel_q;
    end
  end

  // Interrupt flag, held low until cleared; a new event beats the clear.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_n_q <= 1'b1;
    end else if (soft_rst) begin
      irq_n_q <= 1'b1;
    end else if (status_event) begin
      irq_n_q <= 1'b0;
    end else if (irq_clear) begin
      irq_n_q <= 1'b1;
    end
  end

  // Output enables: an output runs unless a pin that governs it is high.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_en_q <= '0;
    end else if (soft_rst) begin
      clk_en_q <= '0;
    end else begin
      clk_en_q <= ~(oe0_mask_q & {NO{pin_q[HPCS_PIN_OE0]}})
                & ~(oe1_mask_q & {NO{pin_q[HPCS_PIN_OE1]}});
    end
  end

  // Lock and reference status pins, registered to keep the pads glitch free.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      locked_q <= '0;
      ref_lost_n_q <= 1'b0;
    end else begin
      locked_q <= loop_locked;
      ref_lost_n_q <= ~(ref_xtal_fail | ref_input_lost);
    end
  end

  // Step generator sees filtered pins only, so a bouncing pin cannot double-step.
  assign sif.soft_rst = soft_rst;
  assign sif.up_lvl = pin_q[HPCS_PIN_UP];
  assign sif.down_lvl = pin_q[HPCS_PIN_DN];
  assign sif.sel = {pin_q[HPCS_PIN_LSEL1], pin_q[HPCS_PIN_LSEL0]};

  hpcs_step_gen #(.NL(NL)) u_step (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sif(sif)
  );

  // Outputs, all straight from flip-flops.
  assign serial_read_out = rd_out_q;
  assign serial_read_out_oe = rd_oe_q;
  assign irq_out_n = irq_n_q;
  assign unlocked_loop_a_n = locked_q[0];
  assign unlocked_loop_b_n = locked_q[1];
  assign unlocked_loop_c_n = locked_q[2];
  assign unlocked_loop_d_n = locked_q[3];
  assign ref_signal_lost_n = ref_lost_n_q;
  assign core_in_reset = rst_q;
  assign i2c_mode = i2c_q;
  assign bus_addr_straps = addr_q;
  assign spi_selected = spi_sel_q;
  assign serial_clk_level = sclk_q;
  assign read_level_sel = rd_lvl_q;
  assign clk_out_en = clk_en_q;
  assign loop_step_up = sif.step_up;
  assign loop_step_down = sif.step_down;
  assign step_size = step_size_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_i2c_no_drive: assert property (i2c_q |-> !rd_oe_q)
    else $error("Shared pin driven in I2C mode.");
  a_spi_drives_data: assert property (rd_oe_q |-> !$past(pin_q[HPCS_PIN_IFSEL])
    && $past(four_wire_q) && rd_out_q == $past(spi_read_bit))
    else $error("Read data driven outside 4-wire SPI.");
  a_read_level: assert property (rd_oe_q |-> rd_lvl_q == $past(io_vdd_sel_q))
    else $error("Read high level does not follow supply select.");
  a_sclk_follow: assert property (##1 sclk_q == $past(pin_q[HPCS_PIN_SCLK]))
    else $error("Serial clock level not passed on.");
  a_addr_zero: assert property (i2c_q && $stable(pin_q) |=>
    addr_q[0] == $past(pin_q[HPCS_PIN_SELN]))
    else $error("Address bit zero strap wrong.");
  a_select_low: assert property (spi_sel_q |-> !$past(pin_q[HPCS_PIN_SELN])
    && !i2c_q)
    else $error("Selected while chip select high.");
  a_irq_sets: assert property (status_event && !soft_rst |=> !irq_n_q)
    else $error("Status change did not assert interrupt.");
  a_reset_defaults: assert property (soft_rst |=> oe0_mask_q == HPCS_OE0_MASK_RST
    && oe1_mask_q == HPCS_OE1_MASK_RST && irq_n_q)
    else $error("Reset did not restore defaults.");
  a_reset_outs_off: assert property (soft_rst |=> clk_en_q == '0)
    else $error("Clock output enabled during reset.");
  a_oe0_disable: assert property (!soft_rst && pin_q[HPCS_PIN_OE0] |=>
    (clk_en_q & $past(oe0_mask_q)) == '0)
    else $error("Enable pin zero high left an output running.");
  a_default_oe: assert property (soft_rst ##1 !soft_rst && !cfg_wr
    && !pin_q[HPCS_PIN_OE0] |=> clk_en_q == '1)
    else $error("Default masks do not enable every output.");
  a_lock_pins: assert property (##1 locked_q == $past(loop_locked))
    else $error("Lock pin does not follow loop lock.");
  a_ref_alarm: assert property (ref_xtal_fail || ref_input_lost |=> !ref_lost_n_q)
    else $error("Reference loss not signalled.");
  a_mode_pin: assert property (##1 i2c_q == $past(pin_q[HPCS_PIN_IFSEL]))
    else $error("Interface mode does not follow select pin.");

endmodule : hpcs_top

// file: testbench/hpcs_host_model.sv
// Host and board model for the shared address-one / read-out pin.
`timescale 1ns/1ps
module hpcs_host_model (
  // Clock
  input wire logic clk_sys,
  // Device side of the shared pin
  input wire logic serial_read_out,
  input wire logic serial_read_out_oe,
  // Board strap control
  input wire logic strap_drive,
  input wire logic strap_value,
  // Resolved wire level
  output logic pin_level
);
  logic last_q;

  // The pin has no pull resistor, so an undriven wire shows the inverse of its last level.
  // Strap or read data resolution.
  always_comb begin
    if (serial_read_out_oe) begin
      pin_level = serial_read_out;
    end else if (strap_drive) begin
      pin_level = strap_value;
    end else begin
      pin_level = ~last_q;
    end
  end

  // Remember the wire level for the floating case.
  always_ff @(posedge clk_sys) begin
    last_q <= pin_level;
  end
endmodule : hpcs_host_model

// file: testbench/tb_top.sv
// Self-checking testbench for the host pin control and status block.
`timescale 1ns/1ps
module tb_top
  import hpcs_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic device_reset_n = 1'b1, iface_sel = 1'b1, select_n = 1'b1, serial_clk = 1'b0;
  logic addr_strap_one, serial_read_out, serial_read_out_oe;
  logic out_en_zero_n = 1'b0, out_en_one_n = 1'b0, freq_step_up = 1'b0, freq_step_down = 1'b0;
  logic [1:0] loop_select = 2'h0;
  logic irq_out_n, unlocked_loop_a_n, unlocked_loop_b_n, unlocked_loop_c_n, unlocked_loop_d_n;
  logic ref_signal_lost_n, core_in_reset, i2c_mode, spi_selected, serial_clk_level;
  logic read_level_sel;
  logic cfg_wr = 1'b0, cfg_four_wire = 1'b1, cfg_io_vdd_sel = 1'b0;
  logic [7:0] cfg_oe0_mask = 8'hff, cfg_oe1_mask = 8'h00, clk_out_en;
  logic [15:0] cfg_step_size = 16'h0001, step_size;
  logic spi_read_bit = 1'b0, spi_read_active = 1'b0, status_event = 1'b0, irq_clear = 1'b0;
  logic [3:0] loop_locked = 4'h0, loop_step_up, loop_step_down;
  logic ref_xtal_fail = 1'b0, ref_input_lost = 1'b0, strap_drive = 1'b1, strap_value = 1'b0;
  logic [1:0] bus_addr_straps;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 54;
  int up_cnt [4] = '{0, 0, 0, 0};
  int dn_cnt [4] = '{0, 0, 0, 0};
  int exp_up [4] = '{0, 0, 0, 0};
  int exp_dn [4] = '{0, 0, 0, 0};

  hpcs_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .device_reset_n(device_reset_n),
    .iface_sel(iface_sel), .select_n(select_n), .serial_clk(serial_clk),
    .addr_strap_one(addr_strap_one), .serial_read_out(serial_read_out),
    .serial_read_out_oe(serial_read_out_oe), .out_en_zero_n(out_en_zero_n),
    .out_en_one_n(out_en_one_n), .loop_select(loop_select), .freq_step_up(freq_step_up),
    .freq_step_down(freq_step_down), .irq_out_n(irq_out_n),
    .unlocked_loop_a_n(unlocked_loop_a_n), .unlocked_loop_b_n(unlocked_loop_b_n),
    .unlocked_loop_c_n(unlocked_loop_c_n), .unlocked_loop_d_n(unlocked_loop_d_n),
    .ref_signal_lost_n(ref_signal_lost_n), .cfg_wr(cfg_wr), .cfg_oe0_mask(cfg_oe0_mask),
    .cfg_oe1_mask(cfg_oe1_mask), .cfg_step_size(cfg_step_size), .cfg_four_wire(cfg_four_wire),
    .cfg_io_vdd_sel(cfg_io_vdd_sel), .spi_read_bit(spi_read_bit),
    .spi_read_active(spi_read_active), .status_event(status_event), .irq_clear(irq_clear),
    .loop_locked(loop_locked), .ref_xtal_fail(ref_xtal_fail), .ref_input_lost(ref_input_lost),
    .core_in_reset(core_in_reset), .i2c_mode(i2c_mode), .bus_addr_straps(bus_addr_straps),
    .spi_selected(spi_selected), .serial_clk_level(serial_clk_level),
    .read_level_sel(read_level_sel), .clk_out_en(clk_out_en), .loop_step_up(loop_step_up),
    .loop_step_down(loop_step_down), .step_size(step_size));

  hpcs_host_model u_host (.clk_sys(clk_sys), .serial_read_out(serial_read_out),
    .serial_read_out_oe(serial_read_out_oe), .strap_drive(strap_drive),
    .strap_value(strap_value), .pin_level(addr_strap_one));

  // A 40 ns clock for the whole run.
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Count every step pulse the design emits, per loop.
  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (loop_step_up[i] === 1'b1) up_cnt[i]++;
      if (loop_step_down[i] === 1'b1) dn_cnt[i]++;
    end
  end

  // Compare one observed value with the model's expectation.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Advance n rising edges, then settle past the edge before driving or sampling.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  // Print the counts and the verdict, then stop.
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // Wait, with a bound, until the internal reset has been released.
  task automatic wait_ready();
    int n;
    n = 0;
    while (core_in_reset !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    if (core_in_reset !== 1'b0) begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_ready

  // Expected enable vector worked out from masks and pin levels.
  function automatic logic [7:0] en_exp(logic [7:0] m0, logic [7:0] m1, logic p0, logic p1);
    return ~((m0 & {8{p0}}) | (m1 & {8{p1}}));
  endfunction : en_exp

  // Load a whole configuration set with a one-cycle write pulse.
  task automatic cfg_load(input logic [7:0] m0, input logic [7:0] m1, input logic [15:0] st);
    cfg_oe0_mask = m0;
    cfg_oe1_mask = m1;
    cfg_step_size = st;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(2);
  endtask : cfg_load

  // Main sequence; every input changes 2 ns after a rising edge.
  initial begin
    logic [7:0] m0, m1;
    logic b;
    tick(5);
    check("rst_en", 32'(clk_out_en), 32'h0);
    check("rst_irq", 32'(irq_out_n), 32'h1);
    check("rst_core", 32'(core_in_reset), 32'h1);
    tick(1);
    arst_n = 1'b1;
    wait_ready();
    tick(2);
    check("def_en", 32'(clk_out_en), 32'hff);
    // Strap values in I2C mode, wire driven by the board.
    for (int v = 0; v < 4; v++) begin
      strap_value = v[1];
      select_n = v[0];
      tick(7);
      check("i2c_mode", 32'(i2c_mode), 32'h1);
      check("straps", 32'(bus_addr_straps), 32'(v));
      check("i2c_oe", 32'(serial_read_out_oe), 32'h0);
    end
    // SPI reads: host selects with a low level and holds the clock high only inside the frame.
    iface_sel = 1'b0;
    strap_drive = 1'b0;
    spi_read_active = 1'b1;
    for (int k = 0; k < 4; k++) begin
      b = 1'($random(seed));
      spi_read_bit = b;
      select_n = k[0];
      serial_clk = ~k[0];
      tick(7);
      check("spi_mode", 32'(i2c_mode), 32'h0);
      check("spi_sel", 32'(spi_selected), 32'(!k[0]));
      check("spi_oe", 32'(serial_read_out_oe), 32'(!k[0]));
      if (k[0] == 1'b0) check("spi_bit", 32'(addr_strap_one), 32'(b));
      check("sclk", 32'(serial_clk_level), 32'(!k[0]));
      check("lvl", 32'(read_level_sel), 32'h0);
    end
    serial_clk = 1'b0;
    cfg_four_wire = 1'b1;
    cfg_io_vdd_sel = 1'b1;
    cfg_load(8'hff, 8'h00, 16'h0001);
    check("lvl_set", 32'(read_level_sel), 32'h1);
    // Three-wire mode keeps the shared pin released even while selected and reading.
    select_n = 1'b0;
    cfg_four_wire = 1'b0;
    cfg_load(8'hff, 8'h00, 16'h0001);
    tick(5);
    check("spi3_oe", 32'(serial_read_out_oe), 32'h0);
    cfg_four_wire = 1'b1;
    cfg_load(8'hff, 8'h00, 16'h0001);
    check("spi4_oe", 32'(serial_read_out_oe), 32'h1);
    select_n = 1'b1;
    // Enable pins against the default masks, then random masks, all four pin combinations each.
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        m0 = 8'($random(seed));
        m1 = 8'($random(seed));
        cfg_load(m0, m1, 16'h0023);
      end
      if (k < 4) begin
        m0 = 8'hff;
        m1 = 8'h00;
      end
      out_en_zero_n = k[0];
      out_en_one_n = k[1];
      tick(7);
      check("oe_en", 32'(clk_out_en), 32'(en_exp(m0, m1, k[0], k[1])));
    end
    check("step_sz", 32'(step_size), 32'h0023);
    out_en_zero_n = 1'b0;
    out_en_one_n = 1'b0;
    // Lock and reference loss indicators.
    for (int k = 0; k < 4; k++) begin
      loop_locked = 4'($random(seed));
      ref_xtal_fail = k[0];
      ref_input_lost = k[1];
      tick(2);
      check("lock", 32'({unlocked_loop_d_n, unlocked_loop_c_n, unlocked_loop_b_n,
        unlocked_loop_a_n}), 32'(loop_locked));
      check("los", 32'(ref_signal_lost_n), 32'(k == 0));
    end
    // Interrupt holds low after a status change until cleared.
    status_event = 1'b1;
    tick(1);
    status_event = 1'b0;
    tick(4);
    check("irq_set", 32'(irq_out_n), 32'h0);
    irq_clear = 1'b1;
    tick(1);
    irq_clear = 1'b0;
    tick(1);
    check("irq_clr", 32'(irq_out_n), 32'h1);
    // A status change in the same cycle as a clear must still leave the interrupt pending.
    status_event = 1'b1;
    irq_clear = 1'b1;
    tick(1);
    status_event = 1'b0;
    irq_clear = 1'b0;
    tick(1);
    check("irq_win", 32'(irq_out_n), 32'h0);
    irq_clear = 1'b1;
    tick(1);
    irq_clear = 1'b0;
    tick(1);
    check("irq_clr2", 32'(irq_out_n), 32'h1);
    // One step per rising edge of each pin, long held, applied only to the chosen loop; both rising at once give none.
    for (int k = 0; k < 9; k++) begin
      loop_select = k[1:0];
      tick(7);
      freq_step_up = (k < 4 || k == 8);
      freq_step_down = (k >= 4);
      // Model expects one step on the selected loop, and none when both pins rise together.
      if (k < 4) exp_up[k[1:0]]++;
      else if (k < 8) exp_dn[k[1:0]]++;
      tick(15);
      freq_step_up = 1'b0;
      freq_step_down = 1'b0;
      tick(7);
    end
    for (int i = 0; i < 4; i++) begin
      check("up_cnt", 32'(up_cnt[i]), 32'(exp_up[i]));
      check("dn_cnt", 32'(dn_cnt[i]), 32'(exp_dn[i]));
    end
    // Device reset pin disables outputs and restores defaults.
    device_reset_n = 1'b0;
    tick(8);
    check("pin_rst_en", 32'(clk_out_en), 32'h0);
    check("pin_rst_core", 32'(core_in_reset), 32'h1);
    device_reset_n = 1'b1;
    wait_ready();
    tick(2);
    check("def_step", 32'(step_size), 32'(HPCS_STEP_SIZE_RST));
    check("def_en2", 32'(clk_out_en), 32'hff);
    check("def_lvl", 32'(read_level_sel), 32'(HPCS_IO_VDD_SEL_RST));
    wrap_up();
  end
endmodule : tb_top
